/* hw/pec_pkg.sv */
package pec_pkg;
	localparam int NUM_A = 4;
	localparam int NUM_B = 4;
	localparam int A_WIDTH = 40;
	localparam int B_WIDTH = 32;
	localparam int NUM_BIN = 4;
	localparam int NUM_SLOTS = NUM_A * 2 + NUM_B;
	localparam int SLOT_AW = 4;
	localparam int BUF_AW = 8;
	localparam logic [7:0] OFF_CTX_CTRL = 8'h00;
	localparam logic [7:0] OFF_STATUS = 8'h04;
	localparam logic [7:0] OFF_MASK = 8'h08;
	localparam logic [7:0] OFF_BUF_BASE = 8'h0C;
	localparam logic [7:0] OFF_BUF_SIZE = 8'h10;
	localparam logic [7:0] OFF_HEAD = 8'h14;
	localparam logic [7:0] OFF_TAIL = 8'h18;
	localparam logic [7:0] OFF_TIMER = 8'h1C;
	localparam logic [7:0] OFF_INVERT = 8'h20;
	localparam logic [7:0] OFF_BOOL_SEL = 8'h24;
	localparam logic [7:0] OFF_CNT_BASE = 8'h40;
	localparam int BIT_STOP_RESUME = 0;
	localparam int BIT_TIMER_EN = 1;
	localparam int BIT_HALF_FULL = 28;
	localparam int BIT_OVERFLOW = 0;
	localparam int BIT_LOST = 1;
	localparam logic [31:0] STATUS_HALF = 32'h1000_0000;
	localparam logic [31:0] STATUS_OVF = 32'h0000_0001;
	localparam logic [31:0] STATUS_LOST = 32'h0000_0002;
	// Only the half-full bit may raise the interrupt; the other status bits are polled.
	localparam logic [31:0] MASK_BITS = 32'h1000_0000;
	localparam logic [31:0] RST_WORD = 32'h0000_0000;
	localparam logic [31:0] RST_BUF_SIZE = 32'h0000_0100;
	localparam logic [31:0] RST_TIMER = 32'h0000_03E8;
	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
	localparam logic [2:0] HSIZE_WORD = 3'h2;
	typedef enum logic [1:0] {
		PEC_IDLE = 2'b00,
		PEC_WRITE = 2'b01,
		PEC_DONE = 2'b11
	} pec_state_t;
endpackage

/* hw/pec_save_if.sv */
`timescale 1ns/10ps
interface pec_save_if;
	logic wr;
	logic [pec_pkg::SLOT_AW-1:0] waddr;
	logic [31:0] wdata;
	logic [pec_pkg::SLOT_AW-1:0] raddr;
	logic [31:0] rdata;
	modport owner (output wr, output waddr, output wdata, output raddr, input rdata);
	modport store (input wr, input waddr, input wdata, input raddr, output rdata);
endinterface

/* hw/pec_save_mem.sv */
`timescale 1ns/10ps
// Power context save area; read data is registered, one cycle after raddr.
module pec_save_mem (
	// Clock
	input wire logic i_core_clk,
	// Port
	pec_save_if.store sv
);
	logic [31:0] mem [pec_pkg::NUM_SLOTS];
	logic [31:0] rdata;
	always_ff @(posedge i_core_clk) begin
		if (sv.wr) begin
			mem[sv.waddr] <= sv.wdata;
		end
		rdata <= mem[sv.raddr];
	end
	assign sv.rdata = rdata;
endmodule

/* hw/pec_top.sv */
// Added by the designer: register access over AHB-Lite and the placing of the registers.
`timescale 1ns/10ps
module pec_top (
	// Clock and global graphics reset
	input wire logic i_core_clk,
	input wire logic i_rst_n,
	// Per-engine reset, which must leave configuration alone
	input wire logic i_engine_rst,
	// AHB-Lite slave
	input wire logic i_hsel,
	input wire logic [31:0] i_haddr,
	input wire logic [1:0] i_htrans,
	input wire logic i_hwrite,
	input wire logic [2:0] i_hsize,
	input wire logic [31:0] i_hwdata,
	input wire logic i_hready,
	output logic [31:0] o_hrdata,
	output logic o_hreadyout,
	output logic o_hresp,
	// Events: aggregating (render) and custom inputs (may carry media)
	input wire logic [pec_pkg::NUM_A-1:0] i_agg_event,
	input wire logic [pec_pkg::NUM_BIN-1:0] i_custom_event,
	// Command streamer
	input wire logic i_report_cmd,
	output logic o_report_busy,
	// Deep idle save and restore
	input wire logic i_idle_save,
	input wire logic i_idle_restore,
	output logic o_idle_busy,
	// Memory write port
	output logic o_mem_valid,
	output logic [31:0] o_mem_addr,
	output logic [31:0] o_mem_data,
	input wire logic i_mem_ready,
	// Interrupt
	output logic o_irq
);
	localparam int SLOT_HI = 2;
	localparam logic [pec_pkg::SLOT_AW-1:0] LAST_SLOT = 4'hB;

	// ****************************************************************
	// Functions
	// ****************************************************************
	function automatic logic [31:0] slot_word(input logic [pec_pkg::SLOT_AW-1:0] s,
			input logic [pec_pkg::A_WIDTH-1:0] a [pec_pkg::NUM_A],
			input logic [pec_pkg::B_WIDTH-1:0] b [pec_pkg::NUM_B]);
		logic [31:0] w;
		w = 32'h0000_0000;
		if (int'(s) < pec_pkg::NUM_A * 2) begin
			if (s[0]) begin
				w = {24'h00_0000, a[s[SLOT_HI:1]][pec_pkg::A_WIDTH-1:32]};
			end else begin
				w = a[s[SLOT_HI:1]][31:0];
			end
		end else if (int'(s) < pec_pkg::NUM_SLOTS) begin
			w = b[s[1:0]];
		end
		return w;
	endfunction

	// ****************************************************************
	// Registers
	// ****************************************************************
	logic [31:0] ctx_ctrl;
	logic [31:0] status;
	logic [31:0] mask;
	logic [31:0] buf_base;
	logic [31:0] buf_size;
	logic [31:0] head;
	logic [31:0] tail;
	logic [31:0] timer_period;
	logic [pec_pkg::NUM_BIN-1:0] invert;
	logic [pec_pkg::NUM_BIN-1:0] bool_sel [pec_pkg::NUM_B];
	logic [pec_pkg::A_WIDTH-1:0] acnt [pec_pkg::NUM_A];
	logic [pec_pkg::B_WIDTH-1:0] bcnt [pec_pkg::NUM_B];

	// ****************************************************************
	// Bus slave
	// ****************************************************************
	logic dp_valid;
	logic dp_write;
	logic [7:0] dp_addr;
	wire logic ap_take = i_hsel && i_hready && i_htrans == pec_pkg::HTRANS_NONSEQ;
	wire logic wr_en = dp_valid && dp_write;
	wire logic rd_en = ap_take && !i_hwrite;
	wire logic [7:0] ap_addr = i_haddr[7:0];
	wire logic status_rd = rd_en && ap_addr == pec_pkg::OFF_STATUS;
	wire logic [7:0] cnt_off = ap_addr - pec_pkg::OFF_CNT_BASE;
	wire logic cnt_hit = ap_addr >= pec_pkg::OFF_CNT_BASE && cnt_off[7:2] < 6'(pec_pkg::NUM_SLOTS);

	always_ff @(posedge i_core_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			dp_valid <= 1'b0;
			dp_write <= 1'b0;
			dp_addr <= 8'h00;
		end else begin
			dp_valid <= ap_take;
			dp_write <= i_hwrite;
			dp_addr <= ap_addr;
		end
	end

	// Read data registered at the address phase: zero-wait for every access.
	logic [31:0] rd_word;
	always_comb begin
		rd_word = 32'h0000_0000;
		if (cnt_hit) begin
			rd_word = slot_word(cnt_off[5:2], acnt, bcnt);
		end else begin
			unique case (ap_addr)
				pec_pkg::OFF_CTX_CTRL: rd_word = ctx_ctrl;
				pec_pkg::OFF_STATUS: rd_word = status;
				pec_pkg::OFF_MASK: rd_word = mask;
				pec_pkg::OFF_BUF_BASE: rd_word = buf_base;
				pec_pkg::OFF_BUF_SIZE: rd_word = buf_size;
				pec_pkg::OFF_HEAD: rd_word = head;
				pec_pkg::OFF_TAIL: rd_word = tail;
				pec_pkg::OFF_TIMER: rd_word = timer_period;
				pec_pkg::OFF_INVERT: rd_word = {28'h000_0000, invert};
				pec_pkg::OFF_BOOL_SEL: rd_word = {16'h0000, bool_sel[3], bool_sel[2],
					bool_sel[1], bool_sel[0]};
				default: rd_word = 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge i_core_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_hrdata <= 32'h0000_0000;
		end else if (rd_en) begin
			o_hrdata <= rd_word;
		end
	end
	assign o_hreadyout = 1'b1;
	assign o_hresp = 1'b0;

	// ****************************************************************
	// Configuration
	// ****************************************************************
	// Only the global reset clears these; i_engine_rst is deliberately unused here.
	always_ff @(posedge i_core_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			ctx_ctrl <= pec_pkg::RST_WORD;
			mask <= pec_pkg::RST_WORD;
			buf_base <= pec_pkg::RST_WORD;
			buf_size <= pec_pkg::RST_BUF_SIZE;
			head <= pec_pkg::RST_WORD;
			timer_period <= pec_pkg::RST_TIMER;
			invert <= 4'h0;
			for (int i = 0; i < pec_pkg::NUM_B; i++) begin
				bool_sel[i] <= 4'h0;
			end
		end else if (wr_en) begin
			unique case (dp_addr)
				pec_pkg::OFF_CTX_CTRL: ctx_ctrl <= {30'h0000_0000, i_hwdata[1:0]};
				pec_pkg::OFF_MASK: mask <= i_hwdata & pec_pkg::MASK_BITS;
				pec_pkg::OFF_BUF_BASE: buf_base <= {i_hwdata[31:2], 2'b00};
				pec_pkg::OFF_BUF_SIZE: buf_size <= {i_hwdata[31:2], 2'b00};
				pec_pkg::OFF_HEAD: head <= {i_hwdata[31:2], 2'b00};
				pec_pkg::OFF_TIMER: timer_period <= i_hwdata;
				pec_pkg::OFF_INVERT: invert <= i_hwdata[3:0];
				pec_pkg::OFF_BOOL_SEL: begin
					for (int i = 0; i < pec_pkg::NUM_B; i++) begin
						bool_sel[i] <= i_hwdata[i*4 +: 4];
					end
				end
				default: ;
			endcase
		end
	end

	// ****************************************************************
	// Counting
	// ****************************************************************
	wire logic run = ctx_ctrl[pec_pkg::BIT_STOP_RESUME];
	wire logic [pec_pkg::NUM_BIN-1:0] cust = i_custom_event ^ invert;
	logic restoring;
	logic [pec_pkg::SLOT_AW-1:0] rst_slot;
	logic rst_data_ok;
	pec_save_if sv();
	pec_save_mem u_mem (
		.i_core_clk(i_core_clk),
		.sv(sv)
	);

	// Aggregating counters see only render events; media goes via Boolean counters.
	always_ff @(posedge i_core_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			for (int i = 0; i < pec_pkg::NUM_A; i++) begin
				acnt[i] <= 40'h00_0000_0000;
			end
			for (int i = 0; i < pec_pkg::NUM_B; i++) begin
				bcnt[i] <= 32'h0000_0000;
			end
		end else if (restoring && rst_data_ok) begin
			// The store answers one cycle late and rst_slot trails rd_slot by that cycle.
			if (int'(rst_slot) < pec_pkg::NUM_A * 2) begin
				if (rst_slot[0]) begin
					acnt[rst_slot[SLOT_HI:1]][39:32] <= sv.rdata[7:0];
				end else begin
					acnt[rst_slot[SLOT_HI:1]][31:0] <= sv.rdata;
				end
			end else begin
				bcnt[rst_slot[1:0]] <= sv.rdata;
			end
		end else if (run) begin
			for (int i = 0; i < pec_pkg::NUM_A; i++) begin
				acnt[i] <= acnt[i] + 40'(i_agg_event[i]);
			end
			for (int i = 0; i < pec_pkg::NUM_B; i++) begin
				if (&(cust | ~bool_sel[i])) begin
					bcnt[i] <= bcnt[i] + 32'h0000_0001;
				end
			end
		end
	end

	// ****************************************************************
	// Deep idle save and restore
	// ****************************************************************
	logic saving;
	logic [pec_pkg::SLOT_AW-1:0] sv_slot;
	logic [pec_pkg::SLOT_AW-1:0] rd_slot;
	always_ff @(posedge i_core_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			saving <= 1'b0;
			restoring <= 1'b0;
			sv_slot <= 4'h0;
			rd_slot <= 4'h0;
			rst_slot <= 4'h0;
			rst_data_ok <= 1'b0;
		end else begin
			if (!saving && !restoring) begin
				saving <= i_idle_save;
				restoring <= i_idle_restore && !i_idle_save;
				sv_slot <= 4'h0;
				rd_slot <= 4'h0;
				rst_slot <= 4'h0;
				rst_data_ok <= 1'b0;
			end else if (saving) begin
				sv_slot <= sv_slot + 4'h1;
				saving <= sv_slot != LAST_SLOT;
			end else begin
				rd_slot <= rd_slot + 4'h1;
				rst_data_ok <= 1'b1;
				rst_slot <= rd_slot;
				restoring <= !(rst_data_ok && rst_slot == LAST_SLOT);
			end
		end
	end
	assign sv.wr = saving;
	assign sv.waddr = sv_slot;
	assign sv.wdata = slot_word(sv_slot, acnt, bcnt);
	assign sv.raddr = rd_slot;
	assign o_idle_busy = saving || restoring;

	// ****************************************************************
	// Report writer
	// ****************************************************************
	pec_pkg::pec_state_t state;
	logic [pec_pkg::SLOT_AW-1:0] wslot;
	logic [31:0] timer;
	logic [31:0] snap [pec_pkg::NUM_SLOTS];
	logic trig_timer;
	logic pend;
	wire logic timer_fire = ctx_ctrl[pec_pkg::BIT_TIMER_EN] && run && timer == 32'h0000_0000;
	wire logic trigger = i_report_cmd || timer_fire;
	wire logic [31:0] rep_bytes = 32'(pec_pkg::NUM_SLOTS) << 2;
	wire logic [31:0] used = tail - head;
	wire logic [31:0] next_tail = (tail + rep_bytes >= buf_size) ? 32'h0000_0000 : tail + rep_bytes;
	wire logic full = buf_size - used <= rep_bytes;
	wire logic half_cross = used < (buf_size >> 1) && used + rep_bytes >= (buf_size >> 1);
	wire logic last_word = i_mem_ready && wslot == LAST_SLOT;

	always_ff @(posedge i_core_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			timer <= pec_pkg::RST_TIMER;
		end else if (timer_fire || !ctx_ctrl[pec_pkg::BIT_TIMER_EN]) begin
			timer <= timer_period;
		end else begin
			timer <= timer - 32'h0000_0001;
		end
	end

	always_ff @(posedge i_core_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			state <= pec_pkg::PEC_IDLE;
			wslot <= 4'h0;
			tail <= pec_pkg::RST_WORD;
			trig_timer <= 1'b0;
			pend <= 1'b0;
			for (int i = 0; i < pec_pkg::NUM_SLOTS; i++) begin
				snap[i] <= 32'h0000_0000;
			end
		end else begin
			unique case (state)
				pec_pkg::PEC_IDLE: begin
					if (trigger && !full) begin
						for (int i = 0; i < pec_pkg::NUM_SLOTS; i++) begin
							snap[i] <= slot_word(4'(i), acnt, bcnt);
						end
						trig_timer <= !i_report_cmd;
						wslot <= 4'h0;
						state <= pec_pkg::PEC_WRITE;
					end
				end
				pec_pkg::PEC_WRITE: begin
					if (i_mem_ready) begin
						wslot <= wslot + 4'h1;
					end
					if (last_word) begin
						state <= pec_pkg::PEC_DONE;
					end
				end
				pec_pkg::PEC_DONE: begin
					tail <= next_tail;
					pend <= trig_timer && half_cross;
					state <= pec_pkg::PEC_IDLE;
				end
			endcase
			if (state != pec_pkg::PEC_DONE) begin
				pend <= 1'b0;
			end
		end
	end
	assign o_report_busy = state != pec_pkg::PEC_IDLE;
	assign o_mem_valid = state == pec_pkg::PEC_WRITE;
	assign o_mem_addr = buf_base + tail + {26'h000_0000, wslot, 2'b00};
	assign o_mem_data = snap[wslot];

	// ****************************************************************
	// Status and interrupt
	// ****************************************************************
	// Set wins over the clear-on-read in the same cycle.
	wire logic lost = trigger && state == pec_pkg::PEC_IDLE && full;
	wire logic ovf = state == pec_pkg::PEC_DONE && next_tail == 32'h0000_0000;
	wire logic [31:0] set_bits = (pend ? pec_pkg::STATUS_HALF : 32'h0000_0000)
		| (lost ? pec_pkg::STATUS_LOST : 32'h0000_0000)
		| (ovf ? pec_pkg::STATUS_OVF : 32'h0000_0000);
	always_ff @(posedge i_core_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			status <= pec_pkg::RST_WORD;
		end else begin
			status <= (status_rd ? 32'h0000_0000 : status) | set_bits;
		end
	end
	assign o_irq = |(status & mask);
endmodule

/* testbench/pec_top_checker.sv */
`timescale 1ns/10ps
// ********
// Port checker
// ********
module pec_top_checker (
	// Clock and reset
	input wire logic i_core_clk,
	input wire logic i_rst_n,
	// Bus
	input wire logic i_hsel,
	input wire logic [1:0] i_htrans,
	input wire logic i_hwrite,
	input wire logic i_hready,
	input wire logic [31:0] o_hrdata,
	input wire logic o_hreadyout,
	input wire logic o_hresp,
	// Reporting, idle and memory
	input wire logic o_report_busy,
	input wire logic o_idle_busy,
	input wire logic o_mem_valid,
	input wire logic [31:0] o_mem_addr,
	input wire logic [31:0] o_mem_data,
	input wire logic i_mem_ready,
	input wire logic o_irq
);
	logic [4:0] words;
	logic [4:0] idle_cyc;
	wire rd_take = i_hsel && i_hready && i_htrans == pec_pkg::HTRANS_NONSEQ && !i_hwrite;
	wire take = o_mem_valid && i_mem_ready;
	always_ff @(posedge i_core_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			words <= 5'h00;
			idle_cyc <= 5'h00;
		end else begin
			words <= o_report_busy ? words + 5'(take) : 5'h00;
			idle_cyc <= o_idle_busy ? idle_cyc + 5'h01 : 5'h00;
		end
	end
	default clocking cb @(posedge i_core_clk); endclocking
	default disable iff (!i_rst_n);
	sequence s_word_taken;
		o_mem_valid && i_mem_ready;
	endsequence
	sequence s_word_waits;
		o_mem_valid && !i_mem_ready;
	endsequence
	a_bus_okay: assert property (o_hreadyout && !o_hresp)
		else $error("bus answer not ready or not okay");
	a_mem_hold: assert property (s_word_waits |=>
		o_mem_valid && $stable(o_mem_addr) && $stable(o_mem_data))
		else $error("stalled report word changed");
	a_mem_step: assert property (s_word_taken ##1 o_mem_valid |->
		o_mem_addr == $past(o_mem_addr) + 32'h4)
		else $error("report word address did not step by four");
	a_mem_in_report: assert property (o_mem_valid |-> o_report_busy)
		else $error("memory write outside a report");
	a_report_words: assert property ($fell(o_report_busy) |-> words == 5'd12)
		else $error("report did not write twelve words");
	a_idle_len: assert property ($fell(o_idle_busy) |-> idle_cyc inside {5'd12, 5'd13})
		else $error("save or restore length wrong");
	a_reset_quiet: assert property (disable iff (1'b0) !i_rst_n |->
		!o_irq && !o_mem_valid && !o_report_busy && !o_idle_busy)
		else $error("outputs active during reset");
	a_rdata_hold: assert property (!rd_take |=> $stable(o_hrdata))
		else $error("read data changed without a read");
endmodule
bind pec_top pec_top_checker u_chk (
	.i_core_clk(i_core_clk), .i_rst_n(i_rst_n), .i_hsel(i_hsel),
	.i_htrans(i_htrans), .i_hwrite(i_hwrite), .i_hready(i_hready),
	.o_hrdata(o_hrdata), .o_hreadyout(o_hreadyout), .o_hresp(o_hresp),
	.o_report_busy(o_report_busy), .o_idle_busy(o_idle_busy),
	.o_mem_valid(o_mem_valid), .o_mem_addr(o_mem_addr), .o_mem_data(o_mem_data),
	.i_mem_ready(i_mem_ready), .o_irq(o_irq)
);

/* testbench/pec_mem_model.sv */
`timescale 1ns/10ps
// ********
// Memory write port model
// ********
// When slow it stalls at random, so the block must hold each word.
module pec_mem_model (
	// Clock and reset
	input wire logic i_core_clk,
	input wire logic i_rst_n,
	// Write port
	input wire logic i_mem_valid,
	input wire logic i_slow,
	output logic o_mem_ready
);
	always @(posedge i_core_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_mem_ready <= 1'b0;
		end else begin
			o_mem_ready <= i_mem_valid && (i_slow ? 1'($urandom_range(1)) : 1'b1);
		end
	end
endmodule

/* testbench/pec_top_tb_top.sv */
`timescale 1ns/10ps
// ********
// Bench
// ********
module pec_top_tb_top;
	localparam logic [31:0] BASE = 32'h0000_1000;
	localparam logic [3:0] INV = 4'h5;
	typedef struct {logic [31:0] x; logic [31:0] y;} pec_exp_t;
	logic clk = 1'b0, rst_n = 1'b1, eng_rst = 1'b0, hsel = 1'b0, hwrite = 1'b0;
	logic rpt = 1'b0, sav = 1'b0, res = 1'b0, slow = 1'b0, mem_chk = 1'b1, rd_dp = 1'b0;
	logic [1:0] htrans = 2'h0;
	logic [31:0] haddr = 32'h0, hwdata = 32'h0;
	// Idle custom inputs sit at the invert pattern, so no Boolean counter fires between bursts.
	logic [3:0] agg = 4'h0, cus = INV;
	wire [31:0] hrdata, maddr, mdata;
	wire hready, hresp, rbusy, ibusy, mvalid, mready, irq;
	pec_exp_t rd_q[$], mem_q[$], nt;
	logic [39:0] ea[4] = '{4{40'h0}};
	logic [31:0] eb[4] = '{4{32'h0}};
	logic [3:0] sel[4] = '{4'h1, 4'h3, 4'h6, 4'hF};
	int failures = 0, comparisons = 0, cycles = 0;
	always #25 clk = ~clk;
	pec_top dut (.i_core_clk(clk), .i_rst_n(rst_n), .i_engine_rst(eng_rst), .i_hsel(hsel),
		.i_haddr(haddr), .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(pec_pkg::HSIZE_WORD),
		.i_hwdata(hwdata), .i_hready(hready), .o_hrdata(hrdata), .o_hreadyout(hready),
		.o_hresp(hresp), .i_agg_event(agg), .i_custom_event(cus), .i_report_cmd(rpt),
		.o_report_busy(rbusy), .i_idle_save(sav), .i_idle_restore(res), .o_idle_busy(ibusy),
		.o_mem_valid(mvalid), .o_mem_addr(maddr), .o_mem_data(mdata), .i_mem_ready(mready),
		.o_irq(irq));
	pec_mem_model u_mem (.i_core_clk(clk), .i_rst_n(rst_n), .i_mem_valid(mvalid),
		.i_slow(slow), .o_mem_ready(mready));
	task automatic end_of_test;
		$display("Counts: %0d comparisons, %0d failures", comparisons, failures);
		if (failures == 0 && comparisons > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	task automatic chk(input string n, input logic [39:0] e, input logic [39:0] g);
		comparisons++;
		if (g !== e) begin
			failures++;
			$display("[ERR] %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
		@(posedge clk);
		hsel <= 1'b1;
		haddr <= a;
		htrans <= pec_pkg::HTRANS_NONSEQ;
		hwrite <= w;
		do @(posedge clk); while (hready !== 1'b1);
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge clk); while (hready !== 1'b1);
		hsel <= 1'b0;
	endtask
	task automatic wr(input logic [31:0] a, input logic [31:0] d);
		bus(1'b1, a, d);
	endtask
	task automatic rd(input logic [31:0] a, input logic [31:0] e, input logic [31:0] m);
		rd_q.push_back('{e & m, m});
		bus(1'b0, a, 32'h0);
	endtask
	function automatic logic [31:0] slot(input int s);
		if (s >= 8) return eb[s - 8];
		return s[0] ? {24'h0, ea[s / 2][39:32]} : ea[s / 2][31:0];
	endfunction
	task automatic rd_cnt;
		for (int s = 0; s < 12; s++) begin
			rd(32'(pec_pkg::OFF_CNT_BASE) + 32'(4 * s), slot(s), (s < 8 && s[0]) ? 32'hFF : '1);
		end
	endtask
	// Random events; expectations advance only when the caller sets acc.
	task automatic count(input int n, input bit acc);
		logic [3:0] a, c;
		repeat (n) begin
			@(posedge clk);
			a = 4'($urandom);
			c = 4'($urandom);
			agg <= a;
			cus <= c;
			for (int k = 0; k < 4; k++) begin
				ea[k] += 40'(acc && a[k]);
				eb[k] += 32'(acc && (&((c ^ INV) | ~sel[k])));
			end
		end
		@(posedge clk);
		agg <= 4'h0;
		cus <= INV;
	endtask
	task automatic pulse(input int k);
		@(posedge clk);
		{rpt, sav, res, eng_rst} <= 4'b1000 >> k;
		@(posedge clk);
		{rpt, sav, res, eng_rst} <= 4'h0;
		@(posedge clk);
	endtask
	task automatic wait_for(input bit k);
		int t = 0;
		while (t < 5000 && (k ? irq !== 1'b1 : (rbusy || ibusy))) begin
			@(posedge clk);
			t++;
		end
		chk("wait", 1'b1, t < 5000);
	endtask
	always @(posedge clk) begin
		cycles++;
		if (cycles == 60000) begin
			failures++;
			end_of_test();
		end
	end
	always @(posedge clk) begin
		if (rd_dp) begin
			nt = rd_q.size() ? rd_q.pop_front() : pec_exp_t'{32'hDEAD, 32'hFFFF};
			chk("hrdata", nt.x, hrdata & nt.y);
		end
		rd_dp <= hsel && htrans == pec_pkg::HTRANS_NONSEQ && !hwrite && hready;
		if (mvalid && mready && mem_chk) begin
			nt = mem_q.size() ? mem_q.pop_front() : pec_exp_t'{32'hDEAD, 32'hDEAD};
			chk("mem_addr", nt.x, maddr);
			chk("mem_data", nt.y, mdata);
		end
	end
	// The deep idle save and restore are each run once by this bench.
	initial begin
		// A real falling edge at time zero, so the design's asynchronous reset takes hold.
		rst_n <= 1'b0;
		void'($urandom(9817));
		repeat (5) @(posedge clk);
		rst_n <= 1'b1;
		rd(32'(pec_pkg::OFF_BUF_SIZE), pec_pkg::RST_BUF_SIZE, '1);
		rd(32'(pec_pkg::OFF_CTX_CTRL), 32'h0, '1);
		wr(32'h0000_00F0, 32'hFFFF_FFFF);
		rd(32'h0000_00F0, 32'h0, '1);
		wr(32'(pec_pkg::OFF_BUF_BASE), BASE);
		wr(32'(pec_pkg::OFF_INVERT), 32'(INV));
		wr(32'(pec_pkg::OFF_BOOL_SEL), 32'h0000_F631);
		wr(32'(pec_pkg::OFF_CTX_CTRL), 32'h1);
		count(300, 1'b1);
		wr(32'(pec_pkg::OFF_CTX_CTRL), 32'h0);
		count(50, 1'b0);
		rd_cnt();
		pulse(3);
		rd(32'(pec_pkg::OFF_INVERT), 32'(INV), '1);
		rd(32'(pec_pkg::OFF_BUF_BASE), BASE, '1);
		slow <= 1'b1;
		for (int s = 0; s < 12; s++) mem_q.push_back('{BASE + 32'(4 * s), slot(s)});
		pulse(0);
		wait_for(1'b0);
		chk("mem_left", 40'h0, 40'(mem_q.size()));
		pulse(1);
		wait_for(1'b0);
		wr(32'(pec_pkg::OFF_CTX_CTRL), 32'h1);
		count(100, 1'b0);
		wr(32'(pec_pkg::OFF_CTX_CTRL), 32'h0);
		pulse(2);
		wait_for(1'b0);
		rd_cnt();
		mem_chk <= 1'b0;
		wr(32'(pec_pkg::OFF_TIMER), 32'h40);
		wr(32'(pec_pkg::OFF_MASK), 32'hFFFF_FFFF);
		rd(32'(pec_pkg::OFF_MASK), pec_pkg::STATUS_HALF, '1);
		wr(32'(pec_pkg::OFF_MASK), pec_pkg::STATUS_HALF);
		wr(32'(pec_pkg::OFF_CTX_CTRL), 32'h3);
		wait_for(1'b1);
		wr(32'(pec_pkg::OFF_MASK), 32'h0);
		@(posedge clk);
		chk("irq_masked", 40'h0, irq);
		wr(32'(pec_pkg::OFF_CTX_CTRL), 32'h0);
		wait_for(1'b0);
		rd(32'(pec_pkg::OFF_STATUS), pec_pkg::STATUS_HALF, 32'hFFFF_FFFC);
		wr(32'(pec_pkg::OFF_MASK), pec_pkg::STATUS_HALF);
		@(posedge clk);
		chk("irq_cleared", 40'h0, irq);
		rst_n <= 1'b0;
		repeat (3) @(posedge clk);
		rst_n <= 1'b1;
		rd(32'(pec_pkg::OFF_INVERT), 32'h0, '1);
		rd(32'(pec_pkg::OFF_TIMER), pec_pkg::RST_TIMER, '1);
		@(posedge clk);
		end_of_test();
	end
endmodule
